// ==== src/uart_port_pkg.sv ====
// Purpose: Shared constants and carriers of the quad UART host bus port
// Assumes: 10 MHz core clock, host pins asynchronous to it
// Notes:   Register indices are per channel, three address lines wide
`default_nettype none
package uart_port_pkg;
	localparam int DATA_W       = 8;
	localparam int REG_ADDR_W   = 3;
	localparam int NUM_CHAN     = 4;
	localparam int FIFO_DEPTH   = 16;

	// **********************************************************
	// Timing
	// **********************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_MIN_NS  = 40;
	localparam int RESET_MIN_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_MIN_CYC = (RESET_MIN_RAW < 1) ? 1 : RESET_MIN_RAW;

	// **********************************************************
	// Register map within a channel
	// **********************************************************
	localparam logic [2:0] REG_DATA       = 3'h0;
	localparam logic [2:0] REG_IRQ_EN     = 3'h1;
	localparam logic [2:0] REG_IRQ_STAT   = 3'h2;
	localparam logic [2:0] REG_LINE_CTRL  = 3'h3;
	localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
	localparam logic [2:0] REG_LINE_STAT  = 3'h5;
	localparam logic [2:0] REG_MODEM_STAT = 3'h6;
	localparam logic [2:0] REG_SCRATCH    = 3'h7;

	localparam logic [7:0] REG_RESET_VAL  = 8'h00;
	localparam int IER_RX_BIT      = 0;
	localparam int IER_TX_BIT      = 1;
	localparam int MCR_IRQ_GATE    = 3;
	localparam int LSR_RX_AVAIL    = 0;
	localparam int LSR_TX_EMPTY    = 5;
	localparam int LSR_TX_IDLE     = 6;
	localparam int ISR_NONE        = 0;

	localparam logic STYLE_STROBE  = 1'b1;
	localparam logic [3:0] ALL_SEL = 4'hF;
	localparam logic [3:0] NO_SEL  = 4'h0;

	// **********************************************************
	// Carriers
	// **********************************************************
	typedef struct packed {
		logic       bus_style;
		logic [3:0] chan_select_n;
		logic       read_strobe_n;
		logic       write_strobe_n;
		logic       common_select_n;
		logic       read_not_write;
		logic       chan_addr_hi;
		logic       chan_addr_lo;
		logic [2:0] reg_addr;
		logic [7:0] data;
		logic       reset_pin;
		logic       irq_style_select;
	} host_pins_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_beat_t;

	typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} bus_state_t;
endpackage
`default_nettype wire

// ==== src/chan_regs.sv ====
// Purpose: One UART channel register set with transmit and receive FIFOs
// Assumes: Access pulses come from the host port, one cycle each
// Notes:   Serial engine sits outside and drains or fills the FIFOs
`timescale 1ns/1ps
`default_nettype none
module chan_regs #(
	parameter int DEPTH = uart_port_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset_n,
	input  wire logic                   clear,
	// Host access
	input  wire logic                   wr_en,
	input  wire logic                   rd_done,
	input  wire logic [2:0]             addr,
	input  wire logic [7:0]             wdata,
	output logic [7:0]                  rdata,
	output logic [7:0]                  modem_ctrl,
	output logic                        irq,
	// Serial side
	input  wire uart_port_pkg::byte_beat_t rx_in,
	output logic                        rx_ready,
	output var uart_port_pkg::byte_beat_t tx_out,
	input  wire logic                   tx_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0] tx_mem [DEPTH];
	logic [7:0] rx_mem [DEPTH];
	logic [AW:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
	logic [AW:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
	logic [7:0] ier_q, ier_d, lcr_q, lcr_d, mcr_q, mcr_d, spr_q, spr_d;
	logic tx_empty, tx_full, rx_empty, rx_full, tx_push, rx_pop, tx_pop, rx_push;

	// ************************************************************
	// FIFO flags and pointer steps
	// ************************************************************
	always_comb begin
		tx_empty = (tx_wp_q == tx_rp_q);
		rx_empty = (rx_wp_q == rx_rp_q);
		tx_full  = (tx_wp_q[AW] != tx_rp_q[AW]) && (tx_wp_q[AW-1:0] == tx_rp_q[AW-1:0]);
		rx_full  = (rx_wp_q[AW] != rx_rp_q[AW]) && (rx_wp_q[AW-1:0] == rx_rp_q[AW-1:0]);
		tx_push  = wr_en && (addr == uart_port_pkg::REG_DATA) && !tx_full;
		rx_pop   = rd_done && (addr == uart_port_pkg::REG_DATA) && !rx_empty;
		tx_pop   = tx_ready && !tx_empty;
		rx_push  = rx_in.valid && !rx_full;
		tx_wp_d  = clear ? '0 : tx_wp_q + (AW+1)'(tx_push);
		tx_rp_d  = clear ? '0 : tx_rp_q + (AW+1)'(tx_pop);
		rx_wp_d  = clear ? '0 : rx_wp_q + (AW+1)'(rx_push);
		rx_rp_d  = clear ? '0 : rx_rp_q + (AW+1)'(rx_pop);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_wp_q <= '0;
			tx_rp_q <= '0;
			rx_wp_q <= '0;
			rx_rp_q <= '0;
		end else begin
			tx_wp_q <= tx_wp_d;
			tx_rp_q <= tx_rp_d;
			rx_wp_q <= rx_wp_d;
			rx_rp_q <= rx_rp_d;
		end
	end

	// Storage holds no reset; pointers alone define content
	always_ff @(posedge core_clk) begin
		if (tx_push && !clear) begin
			tx_mem[tx_wp_q[AW-1:0]] <= wdata;
		end
		if (rx_push && !clear) begin
			rx_mem[rx_wp_q[AW-1:0]] <= rx_in.data;
		end
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	always_comb begin
		ier_d = ier_q;
		lcr_d = lcr_q;
		mcr_d = mcr_q;
		spr_d = spr_q;
		if (clear) begin
			ier_d = uart_port_pkg::REG_RESET_VAL;
			lcr_d = uart_port_pkg::REG_RESET_VAL;
			mcr_d = uart_port_pkg::REG_RESET_VAL;
			spr_d = uart_port_pkg::REG_RESET_VAL;
		end else if (wr_en) begin
			case (addr)
				uart_port_pkg::REG_IRQ_EN:     ier_d = wdata;
				uart_port_pkg::REG_LINE_CTRL:  lcr_d = wdata;
				uart_port_pkg::REG_MODEM_CTRL: mcr_d = wdata;
				uart_port_pkg::REG_SCRATCH:    spr_d = wdata;
				default:                       ier_d = ier_q;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ier_q <= uart_port_pkg::REG_RESET_VAL;
			lcr_q <= uart_port_pkg::REG_RESET_VAL;
			mcr_q <= uart_port_pkg::REG_RESET_VAL;
			spr_q <= uart_port_pkg::REG_RESET_VAL;
		end else begin
			ier_q <= ier_d;
			lcr_q <= lcr_d;
			mcr_q <= mcr_d;
			spr_q <= spr_d;
		end
	end

	// ************************************************************
	// Read view and serial side
	// ************************************************************
	always_comb begin
		irq   = (ier_q[uart_port_pkg::IER_RX_BIT] && !rx_empty)
		     || (ier_q[uart_port_pkg::IER_TX_BIT] && tx_empty);
		rdata = '0;
		case (addr)
			uart_port_pkg::REG_DATA:       rdata = rx_mem[rx_rp_q[AW-1:0]];
			uart_port_pkg::REG_IRQ_EN:     rdata = ier_q;
			uart_port_pkg::REG_IRQ_STAT:   rdata[uart_port_pkg::ISR_NONE] = !irq;
			uart_port_pkg::REG_LINE_CTRL:  rdata = lcr_q;
			uart_port_pkg::REG_MODEM_CTRL: rdata = mcr_q;
			uart_port_pkg::REG_LINE_STAT: begin
				rdata[uart_port_pkg::LSR_RX_AVAIL] = !rx_empty;
				rdata[uart_port_pkg::LSR_TX_EMPTY] = !tx_full;
				rdata[uart_port_pkg::LSR_TX_IDLE]  = tx_empty;
			end
			uart_port_pkg::REG_SCRATCH:    rdata = spr_q;
			default:                       rdata = '0;
		endcase
		modem_ctrl   = mcr_q;
		rx_ready     = !rx_full;
		tx_out.valid = !tx_empty;
		tx_out.data  = tx_mem[tx_rp_q[AW-1:0]];
	end
endmodule
`default_nettype wire

// ==== src/quad_uart_host_bus_port.sv ====
// Purpose: Host parallel bus port serving four UART channels
// Assumes: Host pins are asynchronous and are synchronised to core_clk
// Notes:   Strap picks strobe style or read/write-line style
//
// Summary of operation
// - Bus style follows the strap: strobe style or read/write-line style.
// - Eight-bit two-way data bus plus three register address lines.
// - Accesses are framed by select and strobe levels only, no UART clock.
// - Strobe style: one low select addresses A, B, C or D; all high none.
// - Strobe style: all four selects low on write stores into every channel.
// - Strobe style: read strobe makes reads, write strobe makes writes.
// - Line style: common select, read-not-write and channel bits frame cycles.
// - Line style: select high deselects; address bits 00..11 pick A..D.
// - Channel address bits decode only in line style.
// - Four channels, each with its own full register set.
// - Each channel has sixteen-byte transmit and receive FIFOs.
// - Shared data bus; only the addressed channel drives reads.
// - Reset returns all channel registers and serial outputs to defaults.
// - Strobe style interrupt enable follows style input and modem control bit 3.
// - Line style reset is active low, same effect when long enough.
`timescale 1ns/1ps
`default_nettype none
module quad_uart_host_bus_port #(
	parameter int NCH   = uart_port_pkg::NUM_CHAN,
	parameter int DEPTH = uart_port_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	// Host pins
	input  wire uart_port_pkg::host_pins_t  host_pins,
	output logic [7:0]                      data_out,
	output logic                            data_oe,
	// Interrupt pins
	output logic [3:0]                      irq_out,
	output logic [3:0]                      irq_oe,
	// Serial side
	input  wire uart_port_pkg::byte_beat_t  rx_in [4],
	output logic [3:0]                      rx_ready,
	output var uart_port_pkg::byte_beat_t   tx_out [4],
	input  wire logic [3:0]                 tx_ready
);
	uart_port_pkg::host_pins_t sync1_q, pins;
	uart_port_pkg::bus_state_t state_q, state_d;
	logic [3:0] sel_q, sel_d, wr_en, rd_done, chan_irq, irq_q, irq_d, oe_q, oe_d;
	logic [2:0] addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d, dout_q, dout_d;
	logic [7:0] rdata [4];
	logic [7:0] modem_control_reg [4];
	logic [3:0] cur_sel, strobe_sel;
	logic read_go, write_go, strobe_style, end_pulse, chan_clear, reset_active;
	logic [3:0] rst_cnt_q, rst_cnt_d;
	logic clear_q, clear_d;

	localparam logic [7:0] NO_DATA = 8'h00;
	// Idle pin image keeps the reset pin inactive, so no clear follows reset
	localparam uart_port_pkg::host_pins_t PINS_IDLE = '{bus_style: uart_port_pkg::STYLE_STROBE,
		chan_select_n: uart_port_pkg::ALL_SEL, read_strobe_n: 1'b1, write_strobe_n: 1'b1,
		common_select_n: 1'b1, read_not_write: 1'b1, chan_addr_hi: 1'b1, chan_addr_lo: 1'b1,
		reg_addr: 3'h7, data: 8'hFF, reset_pin: ~uart_port_pkg::STYLE_STROBE,
		irq_style_select: 1'b1};

	function automatic logic [3:0] decode_chan(input logic hi, input logic lo);
		decode_chan = 4'h1 << {hi, lo};
	endfunction

	function automatic logic single_sel(input logic [3:0] s);
		single_sel = (s != uart_port_pkg::NO_SEL) && ((s & (s - 4'h1)) == uart_port_pkg::NO_SEL);
	endfunction

	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	// Bus cycles are level framed, so sampling them needs no UART clock
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= PINS_IDLE;
			pins    <= PINS_IDLE;
		end else begin
			sync1_q <= host_pins;
			pins    <= sync1_q;
		end
	end

	// ************************************************************
	// Channel decode
	// ************************************************************
	always_comb begin
		strobe_style = (pins.bus_style == uart_port_pkg::STYLE_STROBE);
		strobe_sel   = ~pins.chan_select_n;
		if (strobe_style) begin
			cur_sel  = strobe_sel;
			read_go  = !pins.read_strobe_n && single_sel(strobe_sel);
			write_go = !pins.write_strobe_n && (strobe_sel != uart_port_pkg::NO_SEL);
		end else begin
			cur_sel  = pins.common_select_n ? uart_port_pkg::NO_SEL
			         : decode_chan(pins.chan_addr_hi, pins.chan_addr_lo);
			read_go  = !pins.common_select_n && pins.read_not_write;
			write_go = !pins.common_select_n && !pins.read_not_write;
		end
	end

	// ************************************************************
	// Bus cycle sequencer
	// ************************************************************
	// Writes commit at the trailing edge, when host data is settled
	always_comb begin
		state_d   = state_q;
		sel_d     = sel_q;
		addr_d    = addr_q;
		wdata_d   = wdata_q;
		dout_d    = dout_q;
		end_pulse = 1'b0;
		case (state_q)
			uart_port_pkg::BUS_IDLE: begin
				if (read_go) begin
					state_d = uart_port_pkg::BUS_READ;
					sel_d   = cur_sel;
					addr_d  = pins.reg_addr;
				end else if (write_go) begin
					state_d = uart_port_pkg::BUS_WRITE;
					sel_d   = cur_sel;
					addr_d  = pins.reg_addr;
					wdata_d = pins.data;
				end
			end
			uart_port_pkg::BUS_READ: begin
				dout_d = NO_DATA;
				for (int i = 0; i < 4; i++) begin
					if (sel_q[i]) begin
						dout_d = rdata[i];
					end
				end
				if (!read_go) begin
					state_d   = uart_port_pkg::BUS_IDLE;
					end_pulse = 1'b1;
				end
			end
			uart_port_pkg::BUS_WRITE: begin
				if (write_go) begin
					wdata_d = pins.data;
				end else begin
					state_d   = uart_port_pkg::BUS_IDLE;
					end_pulse = 1'b1;
				end
			end
			default: state_d = uart_port_pkg::BUS_IDLE;
		endcase
		if (chan_clear) begin
			state_d = uart_port_pkg::BUS_IDLE;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= uart_port_pkg::BUS_IDLE;
			sel_q   <= uart_port_pkg::NO_SEL;
			addr_q  <= '0;
			wdata_q <= NO_DATA;
			dout_q  <= NO_DATA;
		end else begin
			state_q <= state_d;
			sel_q   <= sel_d;
			addr_q  <= addr_d;
			wdata_q <= wdata_d;
			dout_q  <= dout_d;
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wr_en[i]   = end_pulse && (state_q == uart_port_pkg::BUS_WRITE) && sel_q[i];
			rd_done[i] = end_pulse && (state_q == uart_port_pkg::BUS_READ) && sel_q[i];
		end
		data_out = dout_q;
		data_oe  = (state_q == uart_port_pkg::BUS_READ) && read_go && single_sel(sel_q);
	end

	// ************************************************************
	// Reset pin qualification
	// ************************************************************
	// Pin polarity follows the bus style strap
	always_comb begin
		reset_active = strobe_style ? pins.reset_pin : !pins.reset_pin;
		rst_cnt_d    = reset_active ? ((rst_cnt_q == 4'hF) ? rst_cnt_q : rst_cnt_q + 4'h1) : 4'h0;
		clear_d      = reset_active && (rst_cnt_d >= 4'(uart_port_pkg::RESET_MIN_CYC));
		chan_clear   = clear_q;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_cnt_q <= 4'h0;
			clear_q   <= 1'b0;
		end else begin
			rst_cnt_q <= rst_cnt_d;
			clear_q   <= clear_d;
		end
	end

	// ************************************************************
	// Channels
	// ************************************************************
	for (genvar c = 0; c < NCH; c++) begin : g_chan
		chan_regs #(.DEPTH(DEPTH)) u_chan (
			.core_clk   (core_clk),
			.reset_n    (reset_n),
			.clear      (chan_clear),
			.wr_en      (wr_en[c]),
			.rd_done    (rd_done[c]),
			.addr       (addr_q),
			.wdata      (wdata_q),
			.rdata      (rdata[c]),
			.modem_ctrl (modem_control_reg[c]),
			.irq        (chan_irq[c]),
			.rx_in      (rx_in[c]),
			.rx_ready   (rx_ready[c]),
			.tx_out     (tx_out[c]),
			.tx_ready   (tx_ready[c])
		);
	end

	// ************************************************************
	// Interrupt outputs
	// ************************************************************
	// Gated mode releases the pin so several channels can share a line
	always_comb begin
		irq_d = chan_irq;
		for (int i = 0; i < 4; i++) begin
			oe_d[i] = !strobe_style || pins.irq_style_select
			       || modem_control_reg[i][uart_port_pkg::MCR_IRQ_GATE];
		end
		irq_out = irq_q;
		irq_oe  = oe_q;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_q <= uart_port_pkg::NO_SEL;
			oe_q  <= uart_port_pkg::NO_SEL;
		end else begin
			irq_q <= irq_d;
			oe_q  <= oe_d;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_write_open;
		state_q == uart_port_pkg::BUS_IDLE && write_go && !chan_clear;
	endsequence

	AST_STROBE_DESELECT: assert property (
		strobe_style && pins.chan_select_n == uart_port_pkg::ALL_SEL |-> !read_go && !write_go)
		else $error("Strobe style responded with no select low");
	AST_LINE_DESELECT: assert property (
		!strobe_style && pins.common_select_n |-> !read_go && !write_go && cur_sel == 4'h0)
		else $error("Line style responded with common select high");
	AST_LINE_DECODE: assert property (
		state_q == uart_port_pkg::BUS_IDLE && !strobe_style && read_go && !chan_clear
		|=> sel_q == decode_chan($past(pins.chan_addr_hi), $past(pins.chan_addr_lo)))
		else $error("Line style channel decode wrong");
	AST_BROADCAST: assert property (
		s_write_open ##0 strobe_style && pins.chan_select_n == 4'h0 |=> sel_q == uart_port_pkg::ALL_SEL)
		else $error("Broadcast write did not reach every channel");
	AST_MULTI_READ: assert property (
		strobe_style && !pins.read_strobe_n && !single_sel(~pins.chan_select_n) |-> !read_go)
		else $error("Read taken with several selects");
	AST_OE_ONLY_READ: assert property (
		data_oe |-> state_q == uart_port_pkg::BUS_READ && $onehot(sel_q))
		else $error("Data bus driven outside a single-channel read");
	AST_READ_DATA: assert property (
		state_q == uart_port_pkg::BUS_READ && $past(state_q) == uart_port_pkg::BUS_READ
		&& sel_q == 4'h1 && $past(sel_q) == 4'h1 && $stable(addr_q) && $past(read_go)
		|-> data_out == $past(rdata[0]))
		else $error("Read data not from addressed channel");
	AST_WRITE_COMMIT: assert property (
		state_q == uart_port_pkg::BUS_WRITE && !write_go && !chan_clear |-> wr_en == sel_q)
		else $error("Write strobe end did not commit");
	AST_RESET_CLEAR: assert property (
		chan_clear |=> modem_control_reg[0] == 8'h00 && modem_control_reg[3] == 8'h00 && state_q == uart_port_pkg::BUS_IDLE)
		else $error("Reset pin did not clear channel registers");
	AST_IRQ_GATE: assert property (
		strobe_style && !pins.irq_style_select
		&& !modem_control_reg[1][uart_port_pkg::MCR_IRQ_GATE] |=> !irq_oe[1])
		else $error("Gated interrupt pin driven without enable bit");
endmodule
`default_nettype wire

// ==== dv/host_cpu_model.sv ====
// Purpose: Host processor model driving the parallel bus pins
// Assumes: Pins change at the falling edge of core_clk
// Notes:   Each access is framed by fixed-length select and strobe levels
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
	// Clock
	input  wire logic                      core_clk,
	// Bus
	output var uart_port_pkg::host_pins_t  pins,
	input  wire logic [7:0]                data_out,
	input  wire logic                      data_oe
);
	initial begin
		pins = '0;
		pins.bus_style = uart_port_pkg::STYLE_STROBE;
		pins.chan_select_n = uart_port_pkg::ALL_SEL;
		pins.read_strobe_n = 1'b1;
		pins.write_strobe_n = 1'b1;
		pins.common_select_n = 1'b1;
		pins.read_not_write = 1'b1;
		pins.irq_style_select = 1'b1;
	end

	// **********************************************************
	// Bus cycle, levels only, no dependence on a UART clock
	// **********************************************************
	task automatic access(input logic line, input logic [3:0] sel, input logic [1:0] ch,
			input logic wr, input logic [2:0] ra, input logic [7:0] wd,
			output logic [7:0] rd, output logic oe_seen);
		oe_seen = 1'b0;
		@(negedge core_clk);
		pins.reg_addr = ra;
		pins.data = wr ? wd : ~pins.data;
		if (line) begin
			pins.common_select_n = sel[0];
			pins.read_not_write = ~wr;
			{pins.chan_addr_hi, pins.chan_addr_lo} = ch;
		end else begin
			pins.chan_select_n = sel;
			pins.read_strobe_n = wr;
			pins.write_strobe_n = ~wr;
			{pins.chan_addr_hi, pins.chan_addr_lo} = ~ch;
		end
		repeat (8) begin
			@(negedge core_clk);
			oe_seen = oe_seen | (data_oe === 1'b1);
			if (!wr)
				pins.data = ~pins.data;
		end
		rd = data_out;
		pins.chan_select_n = uart_port_pkg::ALL_SEL;
		pins.read_strobe_n = 1'b1;
		pins.write_strobe_n = 1'b1;
		pins.common_select_n = 1'b1;
		pins.read_not_write = 1'b1;
		// Released bus shows a moving pattern, not the last byte
		repeat (6) begin
			@(negedge core_clk);
			pins.data = ~pins.data;
		end
		// A bus left driven after framing ends spoils the flag
		if (data_oe !== 1'b0)
			oe_seen = 1'bx;
	endtask

	task automatic pin_reset(input int cyc);
		@(negedge core_clk);
		pins.reset_pin = pins.bus_style;
		repeat (cyc) @(negedge core_clk);
		pins.reset_pin = ~pins.bus_style;
		repeat (6) @(negedge core_clk);
	endtask

	// Reset pin idle level moves with the strap so a switch never resets
	task automatic set_mode(input logic line, input logic irq_sel);
		@(negedge core_clk);
		pins.bus_style = ~line;
		pins.reset_pin = line;
		pins.irq_style_select = irq_sel;
		repeat (6) @(negedge core_clk);
	endtask
endmodule
`default_nettype wire

// ==== dv/quad_uart_host_bus_port_tb.sv ====
// Purpose: Self-checking bench of the quad UART host bus port
// Assumes: 10 MHz core clock, host model on the parallel pins
// Notes:   Random data from a fixed seed, corner cases by hand
`timescale 1ns/1ps
`default_nettype none
module quad_uart_host_bus_port_tb;
	logic                       core_clk;
	logic                       reset_n;
	uart_port_pkg::host_pins_t  pins;
	logic [7:0]                 data_out;
	logic                       data_oe;
	logic [3:0]                 irq_out;
	logic [3:0]                 irq_oe;
	logic [3:0]                 rx_ready;
	logic [3:0]                 tx_ready;
	uart_port_pkg::byte_beat_t  rx_in [4];
	uart_port_pkg::byte_beat_t  tx_out [4];
	int                         err_total;
	int                         n_compared;
	int                         seed;
	logic [7:0]                 rd;
	logic [7:0]                 v;
	logic                       oe;
	logic [3:0]                 sel_c;
	logic [7:0]                 exp_q [4];
	logic [7:0]                 q [$];

	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	quad_uart_host_bus_port dut (.core_clk(core_clk), .reset_n(reset_n), .host_pins(pins),
		.data_out(data_out), .data_oe(data_oe), .irq_out(irq_out), .irq_oe(irq_oe),
		.rx_in(rx_in), .rx_ready(rx_ready), .tx_out(tx_out), .tx_ready(tx_ready));
	host_cpu_model cpu (.core_clk(core_clk), .pins(pins), .data_out(data_out),
		.data_oe(data_oe));

	// **********************************************************
	// Checking
	// **********************************************************
	function automatic logic [3:0] one_sel(input int c);
		return ~(4'h1 << c);
	endfunction

	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		err_total++;
		final_report();
	end

	// **********************************************************
	// Scenarios
	// **********************************************************
	initial begin
		err_total = 0;
		n_compared = 0;
		seed = 32'haf18;
		reset_n = 1'b0;
		tx_ready = 4'h0;
		for (int c = 0; c < 4; c++)
			rx_in[c] = '0;
		repeat (20) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (6) @(negedge core_clk);
		for (int c = 0; c < 4; c++) begin
			check("rx_ready", 8'(rx_ready[c]), 8'h01);
			check("tx_valid", 8'(tx_out[c].valid), 8'h00);
			cpu.access(0, one_sel(c), 2'h0, 0, uart_port_pkg::REG_LINE_CTRL, 8'h00, rd, oe);
			check("line_ctrl", rd, uart_port_pkg::REG_RESET_VAL);
		end
		$display("test reset_defaults done");
		for (int c = 0; c < 4; c++) begin
			exp_q[c] = 8'($random(seed));
			cpu.access(0, one_sel(c), 2'h0, 1, uart_port_pkg::REG_SCRATCH, exp_q[c], rd, oe);
			check("write_oe", 8'(oe), 8'h00);
		end
		for (int c = 0; c < 4; c++) begin
			cpu.access(0, one_sel(c), 2'h0, 0, uart_port_pkg::REG_SCRATCH, 8'h00, rd, oe);
			check("strobe_read", rd, exp_q[c]);
			check("read_oe", 8'(oe), 8'h01);
		end
		cpu.access(0, 4'hF, 2'h0, 0, uart_port_pkg::REG_SCRATCH, 8'h00, rd, oe);
		check("none_oe", 8'(oe), 8'h00);
		cpu.access(0, 4'hC, 2'h0, 0, uart_port_pkg::REG_SCRATCH, 8'h00, rd, oe);
		check("multi_oe", 8'(oe), 8'h00);
		$display("test strobe_select done");
		v = 8'($random(seed));
		cpu.access(0, 4'h0, 2'h0, 1, uart_port_pkg::REG_SCRATCH, v, rd, oe);
		for (int c = 0; c < 4; c++) begin
			cpu.access(0, one_sel(c), 2'h0, 0, uart_port_pkg::REG_SCRATCH, 8'h00, rd, oe);
			check("broadcast", rd, v);
		end
		$display("test broadcast done");
		cpu.set_mode(1, 1);
		for (int c = 0; c < 4; c++) begin
			exp_q[c] = 8'($random(seed));
			cpu.access(1, 4'h0, 2'(c), 1, uart_port_pkg::REG_SCRATCH, exp_q[c], rd, oe);
		end
		cpu.access(1, 4'h1, 2'h0, 1, uart_port_pkg::REG_SCRATCH, ~exp_q[0], rd, oe);
		cpu.access(1, 4'h1, 2'h0, 0, uart_port_pkg::REG_SCRATCH, 8'h00, rd, oe);
		check("line_desel_oe", 8'(oe), 8'h00);
		for (int c = 0; c < 4; c++) begin
			cpu.access(1, 4'h0, 2'(c), 0, uart_port_pkg::REG_SCRATCH, 8'h00, rd, oe);
			check("line_read", rd, exp_q[c]);
		end
		$display("test line_style done");
		for (int m = 1; m >= 0; m--) begin
			sel_c = m[0] ? 4'h0 : one_sel(2);
			cpu.set_mode(m[0], 1);
			cpu.access(m[0], sel_c, 2'h2, 1, uart_port_pkg::REG_SCRATCH, 8'h5A, rd, oe);
			cpu.access(m[0], sel_c, 2'h2, 0, uart_port_pkg::REG_SCRATCH, 8'h00, rd, oe);
			check("pre_reset", rd, 8'h5A);
			cpu.pin_reset(3);
			cpu.access(m[0], sel_c, 2'h2, 0, uart_port_pkg::REG_SCRATCH, 8'h00, rd, oe);
			check("pin_reset", rd, uart_port_pkg::REG_RESET_VAL);
		end
		$display("test pin_reset done");
		q.delete();
		for (int i = 0; i < 17; i++) begin
			q.push_back(8'($random(seed)));
			cpu.access(0, one_sel(1), 2'h0, 1, uart_port_pkg::REG_DATA, q[i], rd, oe);
		end
		for (int i = 0; i < 16; i++) begin
			check("tx_data", tx_out[1].data, q[i]);
			check("tx_valid", 8'(tx_out[1].valid), 8'h01);
			tx_ready[1] = 1'b1;
			@(negedge core_clk);
			tx_ready[1] = 1'b0;
		end
		check("tx_drained", 8'(tx_out[1].valid), 8'h00);
		q.delete();
		repeat (40) begin
			@(negedge core_clk);
			if (rx_ready[2] === 1'b1) begin
				rx_in[2].data = 8'($random(seed));
				rx_in[2].valid = 1'b1;
				q.push_back(rx_in[2].data);
			end else
				rx_in[2].valid = 1'b0;
		end
		check("rx_count", 8'(q.size()), 8'(uart_port_pkg::FIFO_DEPTH));
		for (int i = 0; i < 2; i++) begin
			cpu.access(0, one_sel(2), 2'h0, 0, uart_port_pkg::REG_DATA, 8'h00, rd, oe);
			check("rx_data", rd, q[i]);
		end
		check("rx_ready_back", 8'(rx_ready[2]), 8'h01);
		$display("test fifo done");
		cpu.set_mode(0, 0);
		check("irq_gated", 8'(irq_oe), 8'h00);
		cpu.access(0, one_sel(3), 2'h0, 1, uart_port_pkg::REG_MODEM_CTRL, 8'h08, rd, oe);
		check("irq_oe_d", 8'(irq_oe), 8'h08);
		cpu.access(0, one_sel(3), 2'h0, 1, uart_port_pkg::REG_IRQ_EN, 8'h02, rd, oe);
		check("irq_out_d", 8'(irq_out[3]), 8'h01);
		cpu.set_mode(0, 1);
		check("irq_always", 8'(irq_oe), 8'h0F);
		$display("test irq_style done");
		final_report();
	end
endmodule
`default_nettype wire
